//--- rbe_pkg.sv
/*
 rbe_pkg: constants, register offsets and state encodings for the ROM
 boot-entry sequencer and host transaction controller.
 Assumes a 25 MHz core clock and a byte-wide flash read port.
*/
package rbe_pkg;
    localparam int CLK_HZ = 25000000;
    localparam int MS_PER_S = 1000;
    localparam int MS_CYC_DEF = CLK_HZ / MS_PER_S;
    localparam logic [15:0] DET_TMO_DEF_MS = 16'd5000;
    localparam logic [15:0] DET_TMO_BLANK = 16'hffff;
    localparam logic [11:0] OPT_ADDR = 12'h40d;
    localparam logic [11:0] CFG_ADDR = 12'h3c0;
    localparam int CFG_LEN = 30;
    localparam logic [31:0] CFG_TAG = 32'h6766636b;
    localparam logic [7:0] CFG_BLANK = 8'hff;
    localparam int CFG_PERIPH = 16;
    localparam int CFG_TMO_LO = 18;
    localparam int CFG_TMO_HI = 19;
    localparam int CFG_CLKFLAGS = 28;
    localparam int CFG_DIV = 29;
    localparam int OPT_ROM_BIT = 7;
    localparam int OPT_PINFN_BIT = 1;
    localparam int PERIPH_N = 5;
    localparam int PERIPH_USB = 4;
    localparam int FAST_CLK_BIT = 0;
    localparam logic [7:0] CORE_DIV_USB_MAX = 8'h02;
    localparam logic [7:0] CORE_DIV_RST = 8'h00;
    localparam logic [7:0] BUS_DIV_START = 8'h01;
    localparam logic [31:0] REF_KHZ = 32'd48000;
    localparam logic [31:0] BUS_MAX_KHZ = 32'd24000;
    localparam logic [1:0] FORCE_BITS = 2'h3;
    localparam logic [31:0] ROM_VEC_BASE = 32'h1c000000;
    localparam logic [31:0] FLASH_VEC_BASE = 32'h00000000;
    localparam logic [31:0] API_PTR_OFF = 32'h0000001c;
    localparam int MEM_INIT_CYC = 16;
    localparam logic [7:0] FRAME_START = 8'h5a;
    localparam logic [7:0] FRAME_ACK = 8'ha1;
    localparam logic [7:0] FRAME_NAK = 8'ha2;
    localparam logic [7:0] FRAME_ACK_ABORT = 8'ha3;
    localparam logic [7:0] FRAME_TYPE_COMMAND = 8'ha4;
    localparam logic [7:0] FRAME_TYPE_PAYLOAD = 8'ha5;
    localparam logic [7:0] STATUS_OK = 8'h00;
    localparam logic [7:0] STATUS_ABORT_DATA = 8'h01;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_TX = 8'h08;
    localparam logic [7:0] REG_CLK = 8'h0c;
    localparam logic [7:0] REG_REJ = 8'h10;
    typedef enum logic [1:0] {
        DIR_NONE = 2'h0, DIR_IN = 2'h1, DIR_OUT = 2'h2
    } rbe_dir_t;
    typedef enum logic [1:0] {
        TX_GENERIC = 2'h0, TX_READ = 2'h1, TX_DATA = 2'h2
    } rbe_tx_t;
    typedef enum logic [3:0] {
        ST_OPT = 4'h0, ST_FORCE = 4'h1, ST_MEM = 4'h2, ST_CFG = 4'h3,
        ST_CLK = 4'h4, ST_PERI = 4'h5, ST_DET = 4'h6, ST_CMDPH = 4'h7,
        ST_APP = 4'h8
    } rbe_boot_t;
    typedef enum logic [2:0] {
        PH_IDLE = 3'h0, PH_CMD = 3'h1, PH_RESP = 3'h2, PH_DIN = 3'h3,
        PH_DOUT = 3'h4, PH_FINAL = 3'h5
    } rbe_phase_t;
endpackage : rbe_pkg

//--- rbe_top.sv
/*
 rbe_top: boot-entry sequencer and host transaction controller.
 Assumes a classic Wishbone master, a byte flash port on the same clock,
 and a framer on the same clock that decodes host packets.
*/
// The register addresses and the Wishbone register port are this design's own decisions.
// Contract
// [R1] option byte bit 7 set starts the ROM out of reset
// [R2] boot-select pin enters ROM only when pin-function bit is zero
// [R3] option byte fetched from flash 0x40D; blank flash boots ROM
// [R4] NMI suppressed while ROM runs after a ROM boot from reset
// [R5] vector fetches go to ROM table at 0x1C00_0000 after reset boot
// [R6] first step sets force-ROM bits in the reset mode register
// [R7] config at 0x3C0 used only with good tag, else all 0xFF
// [R8] steps: force-ROM, memory, config, clocks, peripherals, detect
// [R9] detection timeout jumps to the user application
// [R10] activity shuts other peripherals and enters command phase
// [R11] 48 MHz reference on when fast flag cleared or USB enabled
// [R12] core divider is inverted byte, clamped to 2 with USB
// [R13] bus divider starts at 1, rises until bus clock within maximum
// [R14] API pointer at table offset 0x1C; entry called with null arg
// [R15] every host command gets a response packet
// [R16] incoming data: command, response, data packets, final response
// [R17] host sends nothing while a response is outstanding
// [R18] non-success response before incoming data aborts the phase
// [R19] target ends incoming data early; host ends with empty packet
// [R20] outgoing data: command, read response with flag, data, final
// [R21] host aborts outgoing early; target ends with empty packet
// [R22] final response covers whole operation; acks accepted anytime
// [R23] command frames type 0xA4, data frames 0xA5, start byte 0x5A
// [R24] phase state kept; out-of-sequence packets are rejected
`timescale 1ns/100ps
module rbe_top
    import rbe_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYC_DEF
)(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic flash_rd_o,
    output logic [11:0] flash_addr_o,
    input wire logic flash_ack_i,
    input wire logic [7:0] flash_dat_i,
    input wire logic boot_select_pin_i,
    input wire logic nmi_pin_i,
    input wire logic nmi_enable_i,
    output logic nmi_o,
    input wire logic [7:0] cpu_vec_off_i,
    output logic [31:0] vec_addr_o,
    output logic [1:0] force_rom_o,
    output logic mem_init_o,
    output logic ref48_en_o,
    output logic [7:0] core_div_o,
    output logic [7:0] bus_div_o,
    input wire logic [PERIPH_N-1:0] periph_active_i,
    output logic [PERIPH_N-1:0] periph_en_o,
    output logic jump_app_o,
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_type_i,
    input wire logic [1:0] rx_dir_i,
    input wire logic rx_zero_i,
    input wire logic rx_abort_i,
    output logic tx_valid_o,
    output logic [7:0] tx_type_o,
    output logic [1:0] tx_kind_o,
    output logic [7:0] tx_status_o,
    output logic tx_flag_o,
    output logic tx_zero_o
);
    rbe_boot_t boot_reg;
    rbe_phase_t phase_reg;
    rbe_dir_t dir_reg;
    logic [1:0] pin_sync_reg, nmi_sync_reg;
    logic rom_reset_reg, reject_reg, rom_call_reg, ack_reg;
    logic [7:0] opt_reg, cnt_reg, rej_cnt_reg;
    logic [7:0] cfg_mem [0:CFG_LEN-1];
    logic [15:0] ms_reg;
    logic [31:0] cyc_reg, rd_data;
    logic wb_req, wb_wr, tx_go, rx_ok, tx_ok, cfg_ok, usb_en, hs_mode;
    logic [7:0] cfg_byte [0:CFG_LEN-1];
    logic [7:0] inv_div, core_div_w;
    logic [15:0] tmo_ms;
    logic [PERIPH_N-1:0] act_mask, first_act;
    logic [1:0] tx_kind_w;
    logic [7:0] tx_stat_w;

    // synchronisers: first stage feeds only the second
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_sync_reg <= 2'h0;
            nmi_sync_reg <= 2'h0;
        end
        else
        begin
            pin_sync_reg <= {pin_sync_reg[0], boot_select_pin_i};
            nmi_sync_reg <= {nmi_sync_reg[0], nmi_pin_i};
        end
    end

    // wishbone slave: ack one cycle after request, dropped next cycle
    assign wb_req = wb_cyc_i && wb_stb_i;
    assign wb_wr = wb_req && wb_we_i && ack_reg;
    assign tx_go = wb_wr && wb_adr_i == REG_TX && wb_sel_i[0];
    assign tx_kind_w = wb_dat_i[1:0];
    assign tx_stat_w = wb_dat_i[15:8];
    assign wb_ack_o = ack_reg;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_reg <= 1'b0;
        else
            ack_reg <= wb_req && !ack_reg;
    end

    always_comb
    begin
        unique case (wb_adr_i)
            REG_STAT: rd_data = {16'h0, rej_cnt_reg[0], 1'b0, periph_en_o,
                                 reject_reg, rom_reset_reg, phase_reg, boot_reg};
            REG_CLK: rd_data = {7'h0, ref48_en_o, force_rom_o, 6'h0,
                                bus_div_o, core_div_o};
            REG_REJ: rd_data = {24'h0, rej_cnt_reg};
            default: rd_data = 32'h0;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_dat_o <= 32'h0;
        else
            wb_dat_o <= (wb_req && !wb_we_i) ? rd_data : 32'h0;
    end

    // software call through the ROM entry pointer; arg is unused
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rom_call_reg <= 1'b0;
        else
            rom_call_reg <= wb_wr && wb_adr_i == REG_CTRL && wb_sel_i[0]
                            && wb_dat_i[0]; // [R14]
    end

    // configuration view: blank values unless the tag matches
    assign cfg_ok = {cfg_mem[3], cfg_mem[2], cfg_mem[1], cfg_mem[0]}
                    == CFG_TAG;
    genvar gi;
    generate
        for (gi = 0; gi < CFG_LEN; gi++)
        begin : g_cfg
            assign cfg_byte[gi] = cfg_ok ? cfg_mem[gi] : CFG_BLANK; // [R7]
        end
    endgenerate
    assign usb_en = cfg_byte[CFG_PERIPH][PERIPH_USB];
    assign hs_mode = !cfg_byte[CFG_CLKFLAGS][FAST_CLK_BIT];
    assign inv_div = ~cfg_byte[CFG_DIV];
    // bus divider search needs the new core divider, not the stale one
    assign core_div_w = !hs_mode ? core_div_o
                        : (usb_en && inv_div > CORE_DIV_USB_MAX)
                        ? CORE_DIV_USB_MAX : inv_div; // [R12]
    assign tmo_ms = ({cfg_byte[CFG_TMO_HI], cfg_byte[CFG_TMO_LO]}
                    == DET_TMO_BLANK) ? DET_TMO_DEF_MS
                    : {cfg_byte[CFG_TMO_HI], cfg_byte[CFG_TMO_LO]};
    assign act_mask = periph_active_i & periph_en_o;
    assign first_act = act_mask & (~act_mask + PERIPH_N'(1));

    // start-up sequencer
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            boot_reg <= ST_OPT;
            opt_reg <= 8'h0;
            rom_reset_reg <= 1'b0;
            cnt_reg <= 8'h0;
            cyc_reg <= 32'h0;
            ms_reg <= 16'h0;
            force_rom_o <= 2'h0;
            ref48_en_o <= 1'b0;
            core_div_o <= CORE_DIV_RST;
            bus_div_o <= BUS_DIV_START;
            periph_en_o <= '0;
            jump_app_o <= 1'b0;
        end
        else
        begin
            unique case (boot_reg)
                ST_OPT:
                    if (flash_ack_i)
                    begin
                        opt_reg <= flash_dat_i;
                        // erased flash reads ones, so blank parts boot ROM
                        if (flash_dat_i[OPT_ROM_BIT] // [R1] [R3]
                            || (pin_sync_reg[1]
                                && !flash_dat_i[OPT_PINFN_BIT])) // [R2]
                        begin
                            rom_reset_reg <= 1'b1; // [R4] [R5]
                            boot_reg <= ST_FORCE;
                        end
                        else
                        begin
                            jump_app_o <= 1'b1;
                            boot_reg <= ST_APP;
                        end
                    end
                ST_FORCE:
                begin
                    force_rom_o <= FORCE_BITS; // [R6]
                    cnt_reg <= 8'h0;
                    boot_reg <= ST_MEM; // [R8]
                end
                ST_MEM:
                begin
                    cnt_reg <= cnt_reg + 8'h1;
                    if (cnt_reg == 8'(MEM_INIT_CYC - 1))
                    begin
                        cnt_reg <= 8'h0;
                        boot_reg <= ST_CFG; // [R8]
                    end
                end
                ST_CFG:
                    if (flash_ack_i)
                    begin
                        cnt_reg <= cnt_reg + 8'h1;
                        if (cnt_reg == 8'(CFG_LEN - 1))
                        begin
                            bus_div_o <= BUS_DIV_START; // [R13]
                            boot_reg <= ST_CLK; // [R8]
                        end
                    end
                ST_CLK:
                begin
                    // default keeps the dividers as they came out of reset
                    ref48_en_o <= hs_mode || usb_en; // [R11]
                    core_div_o <= core_div_w; // [R12]
                    // one step per cycle: no divider in hardware
                    if (hs_mode && REF_KHZ > BUS_MAX_KHZ
                        * (32'(core_div_w) + 32'h1) * 32'(bus_div_o))
                        bus_div_o <= bus_div_o + 8'h1; // [R13]
                    else
                        boot_reg <= ST_PERI; // [R8]
                end
                ST_PERI:
                begin
                    periph_en_o <= cfg_byte[CFG_PERIPH][PERIPH_N-1:0];
                    cyc_reg <= 32'h0;
                    ms_reg <= 16'h0;
                    boot_reg <= ST_DET; // [R8]
                end
                ST_DET:
                    if (act_mask != '0)
                    begin
                        periph_en_o <= first_act; // [R10]
                        boot_reg <= ST_CMDPH;
                    end
                    else if (ms_reg >= tmo_ms)
                    begin
                        periph_en_o <= '0;
                        rom_reset_reg <= 1'b0;
                        jump_app_o <= 1'b1; // [R9]
                        boot_reg <= ST_APP;
                    end
                    else if (cyc_reg == 32'(MS_CYCLES - 1))
                    begin
                        cyc_reg <= 32'h0;
                        ms_reg <= ms_reg + 16'h1;
                    end
                    else
                        cyc_reg <= cyc_reg + 32'h1;
                ST_CMDPH: ;
                ST_APP:
                begin
                    jump_app_o <= 1'b0;
                    if (rom_call_reg)
                        boot_reg <= ST_FORCE; // [R14]
                end
                default: boot_reg <= ST_OPT;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (boot_reg == ST_CFG && flash_ack_i)
            cfg_mem[cnt_reg[4:0]] <= flash_dat_i;
    end

    assign flash_rd_o = boot_reg == ST_OPT || boot_reg == ST_CFG;
    assign flash_addr_o = boot_reg == ST_OPT ? OPT_ADDR // [R3]
                          : CFG_ADDR + 12'(cnt_reg); // [R7]
    assign mem_init_o = boot_reg == ST_MEM;
    // pin is NMI by default; masked while ROM runs after reset boot
    assign nmi_o = nmi_sync_reg[1] && nmi_enable_i && !rom_reset_reg; // [R4]

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            vec_addr_o <= FLASH_VEC_BASE;
        else
            vec_addr_o <= (rom_reset_reg ? ROM_VEC_BASE : FLASH_VEC_BASE)
                          + 32'(cpu_vec_off_i); // [R5]
    end

    // transaction phase tracking; acks and naks never change phase
    assign rx_ok = rx_valid_i && rx_type_i != FRAME_ACK
                   && rx_type_i != FRAME_NAK
                   && rx_type_i != FRAME_ACK_ABORT; // [R22]
    always_comb
    begin
        unique case (phase_reg)
            PH_RESP, PH_FINAL: tx_ok = tx_kind_w != TX_DATA; // [R15]
            PH_DIN: tx_ok = tx_kind_w == TX_GENERIC; // [R19]
            PH_DOUT: tx_ok = tx_kind_w != TX_READ; // [R20]
            default: tx_ok = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            phase_reg <= PH_IDLE;
            dir_reg <= DIR_NONE;
            reject_reg <= 1'b0;
            rej_cnt_reg <= 8'h0;
        end
        else if (boot_reg != ST_CMDPH)
            phase_reg <= PH_IDLE;
        else
        begin
            if (phase_reg == PH_IDLE)
                phase_reg <= PH_CMD; // [R10]
            else if (rx_ok)
                unique case (phase_reg)
                    PH_CMD:
                        if (rx_type_i == FRAME_TYPE_COMMAND) // [R23]
                        begin
                            dir_reg <= rbe_dir_t'(rx_dir_i);
                            phase_reg <= PH_RESP;
                        end
                    PH_DIN:
                        if (rx_type_i == FRAME_TYPE_PAYLOAD && rx_zero_i)
                            phase_reg <= PH_FINAL; // [R19]
                    PH_DOUT:
                        if (rx_type_i == FRAME_TYPE_COMMAND && rx_abort_i)
                            phase_reg <= PH_FINAL; // [R21]
                    default: ;
                endcase
            else if (tx_go && tx_ok)
                unique case (phase_reg)
                    PH_RESP:
                        if (tx_kind_w == TX_GENERIC && dir_reg == DIR_IN
                            && tx_stat_w == STATUS_OK)
                            phase_reg <= PH_DIN; // [R16]
                        else if (tx_kind_w == TX_READ && dir_reg == DIR_OUT
                                 && wb_dat_i[2])
                            phase_reg <= PH_DOUT; // [R20]
                        else
                            phase_reg <= PH_CMD; // [R18]
                    PH_DOUT:
                        if (tx_kind_w == TX_GENERIC)
                            phase_reg <= PH_CMD;
                        else if (wb_dat_i[3])
                            phase_reg <= PH_FINAL; // [R21]
                    default: phase_reg <= PH_CMD; // [R22]
                endcase
            // set wins over software clear
            if ((rx_ok && !(phase_reg == PH_CMD
                            && rx_type_i == FRAME_TYPE_COMMAND)
                       && !(phase_reg == PH_DIN
                            && rx_type_i == FRAME_TYPE_PAYLOAD)
                       && !(phase_reg == PH_DOUT && rx_abort_i))
                || (tx_go && !tx_ok))
            begin
                reject_reg <= 1'b1; // [R17] [R24]
                rej_cnt_reg <= rej_cnt_reg + 8'h1;
            end
            else if (wb_wr && wb_adr_i == REG_CTRL && wb_dat_i[1])
                reject_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            tx_valid_o <= 1'b0;
            tx_type_o <= FRAME_TYPE_COMMAND;
            tx_kind_o <= TX_GENERIC;
            tx_status_o <= STATUS_OK;
            tx_flag_o <= 1'b0;
            tx_zero_o <= 1'b0;
        end
        else
        begin
            tx_valid_o <= tx_go && tx_ok && boot_reg == ST_CMDPH && !rx_ok;
            if (tx_go)
            begin
                tx_type_o <= tx_kind_w == TX_DATA ? FRAME_TYPE_PAYLOAD
                             : FRAME_TYPE_COMMAND; // [R23]
                tx_kind_o <= tx_kind_w;
                tx_status_o <= tx_stat_w;
                tx_flag_o <= wb_dat_i[2];
                tx_zero_o <= wb_dat_i[3];
            end
        end
    end

    sequence s_force_start;
        boot_reg == ST_FORCE;
    endsequence
    sequence s_mem_run;
        boot_reg == ST_MEM [*8];
    endsequence

    AST_OPT_ADDR: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
        boot_reg == ST_OPT |-> flash_addr_o == OPT_ADDR)
        else $error("option byte address wrong");
    AST_ROM_BOOT: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
        boot_reg == ST_OPT && flash_ack_i && flash_dat_i[OPT_ROM_BIT]
        |=> boot_reg == ST_FORCE ##1 force_rom_o == FORCE_BITS)
        else $error("rom boot not taken");
    AST_PIN_BOOT: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
        boot_reg == ST_OPT && flash_ack_i && !flash_dat_i[OPT_ROM_BIT]
        && flash_dat_i[OPT_PINFN_BIT] |=> boot_reg == ST_APP)
        else $error("pin boot while pin is nmi");
    AST_NMI_MASK: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
        rom_reset_reg |-> !nmi_o)
        else $error("nmi during rom run");
    AST_VEC: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
        rom_reset_reg && $stable(rom_reset_reg)
        |=> vec_addr_o == ROM_VEC_BASE + 32'($past(cpu_vec_off_i)))
        else $error("vector not redirected");
    AST_ORDER: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
        s_force_start |=> s_mem_run ##[8:8] boot_reg == ST_MEM
        ##1 boot_reg == ST_CFG)
        else $error("start-up order broken");
    AST_CLAMP: assert property (@(posedge clk_i) disable iff (rst_i) // [R12]
        boot_reg == ST_PERI && usb_en |-> core_div_o <= CORE_DIV_USB_MAX)
        else $error("usb core divider above limit");
    AST_ABORT: assert property (@(posedge clk_i) disable iff (rst_i) // [R18]
        phase_reg == PH_RESP && !rx_ok && tx_go && tx_kind_w == TX_GENERIC
        && tx_stat_w != STATUS_OK && boot_reg == ST_CMDPH
        |=> phase_reg == PH_CMD)
        else $error("data phase not aborted");
    AST_REJECT: assert property (@(posedge clk_i) disable iff (rst_i) // [R24]
        phase_reg == PH_RESP && rx_ok && boot_reg == ST_CMDPH
        |=> reject_reg && rej_cnt_reg == $past(rej_cnt_reg) + 8'h1)
        else $error("out-of-sequence packet accepted");
endmodule : rbe_top

//--- rbe_flash_model.sv
/*
 rbe_flash_model: byte flash holding the option byte and a tagged
 loader config area. Assumes the read request is held until ack.
*/
`timescale 1ns/100ps
module rbe_flash_model
    import rbe_pkg::*;
#(
    parameter logic [7:0] OPT = 8'h80,
    parameter logic [7:0] PERIPH = 8'h07
)(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic rd_i,
    input wire logic [11:0] addr_i,
    output logic ack_o,
    output logic [7:0] dat_o
);
    logic [1:0] cnt_reg;
    function automatic logic [7:0] byte_at(input logic [11:0] a);
        if (a == 12'h40d)
            return OPT; // rom bit set, pin-function bit clear
        case (a - 12'h3c0)
            12'h000: return 8'h6b; // tag bytes, little-endian
            12'h001: return 8'h63;
            12'h002: return 8'h66;
            12'h003: return 8'h67;
            12'h010: return PERIPH;
            12'h012: return 8'h02; // short detect timeout
            12'h013: return 8'h00;
            12'h01c: return 8'hfe; // fast clock flag cleared
            12'h01d: return 8'hfe;
            default: return 8'hff;
        endcase
    endfunction : byte_at
    // slow answer; data line churns outside the ack cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i || ack_o || !rd_i)
        begin
            ack_o <= 1'b0;
            cnt_reg <= 2'h0;
            dat_o <= rst_i ? 8'h00 : ~dat_o;
        end
        else
        begin
            cnt_reg <= cnt_reg + 2'h1;
            ack_o <= (cnt_reg == 2'h1);
            dat_o <= (cnt_reg == 2'h1) ? byte_at(addr_i) : ~dat_o;
        end
    end
endmodule : rbe_flash_model

//--- tb_rom_boot_entry_and_host_protocol.sv
/*
 tb: boot sequence, host transactions and detect timeout.
 Assumes rbe_top and the flash model on one 25 MHz clock.
*/
`timescale 1ns/100ps
module tb_rom_boot_entry_and_host_protocol;
    import rbe_pkg::*;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic flash_rd_o, flash_ack_i, boot_select_pin_i, nmi_pin_i;
    logic nmi_enable_i, nmi_o, mem_init_o, ref48_en_o, jump_app_o;
    logic rx_valid_i, rx_zero_i, rx_abort_i, tx_valid_o, tx_flag_o, tx_zero_o;
    logic [7:0] wb_adr_i, flash_dat_i, cpu_vec_off_i, core_div_o, bus_div_o;
    logic [7:0] rx_type_i, tx_type_o, tx_status_o;
    logic [31:0] wb_dat_i, wb_dat_o, vec_addr_o, q;
    logic [3:0] wb_sel_i;
    logic [11:0] flash_addr_o;
    logic [1:0] force_rom_o, rx_dir_i, tx_kind_o;
    logic [PERIPH_N-1:0] periph_active_i, periph_en_o;
    int error_cnt = 0;
    int n_checks = 0;
    int i;
    rbe_top #(.MS_CYCLES(4)) rbe_top_inst (.*);
    rbe_flash_model rbe_flash_model_inst (.clk_i, .rst_i, .rd_i(flash_rd_o),
        .addr_i(flash_addr_o), .ack_o(flash_ack_i), .dat_o(flash_dat_i));
    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e)
        begin
            error_cnt++;
            $display("[ERR] t=%0t seen %h exp %h", $time, s, e);
        end
    endtask : chk
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : results
    task automatic tmo(input int n);
        if (n >= 1000)
        begin
            error_cnt++;
            results();
        end
    endtask : tmo
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
        i = 0;
        do
        begin
            @(posedge clk_i);
            i++;
        end while (wb_ack_o !== 1'b1 && i < 1000);
        tmo(i);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
    endtask : wb
    // host packet: rx_valid_i pulsed for one cycle, no wait for an answer
    task automatic rx(input logic [7:0] t, input logic [1:0] d);
        @(posedge clk_i);
        {rx_valid_i, rx_type_i, rx_dir_i} <= {1'b1, t, d};
        @(posedge clk_i);
        rx_valid_i <= 1'b0;
    endtask : rx
    task automatic tx(input logic [31:0] d, input logic [7:0] t);
        wb(1'b1, REG_TX, d);
        #1;
        chk(tx_valid_o, 1'b1);
        chk(tx_type_o, t);
    endtask : tx
    task automatic reset();
        rst_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask : reset
    initial
    begin
        {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, boot_select_pin_i} = 5'h10;
        {nmi_pin_i, nmi_enable_i, rx_valid_i, rx_zero_i, rx_abort_i} = 5'h18;
        {wb_adr_i, wb_dat_i, wb_sel_i, rx_type_i, rx_dir_i} = '0;
        wb_sel_i = 4'hf;
        cpu_vec_off_i = 8'h08;
        periph_active_i = '0;
        reset();
        @(posedge clk_i);
        #1;
        chk(flash_addr_o, 12'h40d);
        for (i = 0; i < 1000 && periph_en_o !== 5'h07; i++) @(posedge clk_i);
        tmo(i);
        chk(force_rom_o, 2'h3);
        chk(ref48_en_o, 1'b1);
        chk(core_div_o, 8'h01);
        chk(bus_div_o, 8'h01);
        chk(nmi_o, 1'b0);
        chk(vec_addr_o, 32'h1c000008);
        periph_active_i <= 5'h02;
        for (i = 0; i < 1000 && periph_en_o !== 5'h02; i++) @(posedge clk_i);
        tmo(i);
        wb(1'b0, REG_STAT, 32'h0);
        chk(q[3:0], ST_CMDPH);
        $display("boot test done");
        rx(FRAME_TYPE_PAYLOAD, DIR_NONE);
        wb(1'b0, REG_REJ, 32'h0);
        chk(q, 32'h1); // data packet with no command
        rx(FRAME_TYPE_COMMAND, DIR_NONE);
        tx(32'h0, FRAME_TYPE_COMMAND);
        rx(FRAME_TYPE_COMMAND, DIR_OUT);
        tx(32'h5, FRAME_TYPE_COMMAND); // read response, data follows
        chk(tx_flag_o, 1'b1);
        tx(32'ha, FRAME_TYPE_PAYLOAD); // empty data packet ends phase
        chk(tx_zero_o, 1'b1);
        tx(32'h0, FRAME_TYPE_COMMAND); // final status
        wb(1'b0, REG_REJ, 32'h0);
        chk(q, 32'h1); // legal sequence not refused
        rx(FRAME_TYPE_COMMAND, DIR_IN);
        tx(32'h0, FRAME_TYPE_COMMAND); // ok opens incoming data
        rx(FRAME_TYPE_PAYLOAD, DIR_NONE);
        tx(32'h100, FRAME_TYPE_COMMAND); // early abort-data final
        rx(FRAME_TYPE_COMMAND, DIR_IN);
        tx(32'h200, FRAME_TYPE_COMMAND); // failed status, no data
        rx(FRAME_TYPE_PAYLOAD, DIR_NONE);
        wb(1'b0, REG_REJ, 32'h0);
        chk(q, 32'h2); // only the orphan payload refused
        wb(1'b0, 8'h20, 32'h0);
        chk(q, 32'h0); // unmapped offset reads zero
        $display("host test done");
        periph_active_i <= '0;
        reset();
        for (i = 0; i < 1000 && jump_app_o !== 1'b1; i++) @(posedge clk_i);
        tmo(i); // no host, leave to application
        chk(jump_app_o, 1'b1);
        $display("timeout test done");
        results();
    end
endmodule : tb_rom_boot_entry_and_host_protocol
